// *** design/cpl_consts.vh ***
// Constants for the CPU priority level status block
//
// Functional notes
// RL1 - Status word bits 7..5 hold low priority field, levels 0..7 when high bit clear.
// RL2 - Low field all ones means level 7 or 15; user interrupts blocked.
// RL3 - Level is high bit (control word bit 3) above the three-bit field.
// RL4 - High bit set gives effective levels 8..15, field value plus eight.
// RL5 - While nesting disable is set, software writes to low field are ignored.
// RL6 - Status word bits 15..9 ignore writes and read as zero.
// RL7 - Hardware sets and clears the level itself; permitted software writes apply.
// RL8 - Software can never set the high level bit, only clear it.
// RL9 - Nesting disable bit 15 of control one: one disables nesting, zero allows.
// RL10 - Reset clears all level bits and nesting disable; level 0, nesting on.
`ifndef CPL_CONSTS_VH
`define CPL_CONSTS_VH

// ****************************************
// Register addresses
// ****************************************
`define CPL_ADDR_W          4
`define CPL_ADDR_STATUS     4'h0
`define CPL_ADDR_CONTROL    4'h1
`define CPL_ADDR_INTCTL1    4'h2

// ****************************************
// Field positions
// ****************************************
`define CPL_DATA_W          16
`define CPL_LVL_LO_MSB      7
`define CPL_LVL_LO_LSB      5
`define CPL_LVL_HI_BIT      3
`define CPL_PSV_BIT         2
`define CPL_NSTD_BIT        15
`define CPL_TRAP_MSB        4
`define CPL_TRAP_LSB        1

// ****************************************
// Reset values and codes
// ****************************************
`define CPL_LVL_LO_RST      3'h0
`define CPL_LVL_LO_MAX      3'h7
`define CPL_TRAP_RST        4'h0
`define CPL_RDATA_ZERO      16'h0000

`endif

// *** design/cpl_priority_level.v ***
// CPU priority level status registers with core update port
`timescale 1ns/1ps
`default_nettype none
`include "cpl_consts.vh"

module cpl_priority_level (
  input  wire                     clock_in,
  input  wire                     rst_n_in,
  // Software register port
  input  wire [`CPL_ADDR_W-1:0]   reg_addr_in,
  input  wire [`CPL_DATA_W-1:0]   reg_wdata_in,
  input  wire                     reg_write_in,
  input  wire                     reg_read_in,
  output wire [`CPL_DATA_W-1:0]   reg_rdata_out,
  // Core interrupt and trap sequencer
  input  wire                     hw_level_load_in,
  input  wire [3:0]               hw_level_in,
  input  wire                     arith_error_trap_set_in,
  input  wire                     addr_error_trap_set_in,
  input  wire                     stack_error_trap_set_in,
  input  wire                     osc_fail_trap_set_in,
  // Status towards the core
  output wire [3:0]               cpu_priority_level_out,
  output wire                     user_irq_blocked_out,
  output wire                     nesting_disable_out,
  output wire                     program_space_view_out,
  output wire [3:0]               trap_flags_out
);

  // ****************************************
  // Reset synchronisation
  // ****************************************
  wire rst_n_sync;

  // Core logic leaves reset two edges after release
  cpl_rst_sync u_rst_sync (
    .clock_in       (clock_in),
    .rst_n_in       (rst_n_in),
    .rst_n_sync_out (rst_n_sync)
  );

  // ****************************************
  // Helper functions
  // ****************************************

  // Form four-bit level from high bit and low field
  function [3:0] join_level;
    input       hi;
    input [2:0] lo;
    begin
      join_level = {hi, lo};
    end
  endfunction

  // Select one register by address
  function addr_hit;
    input [`CPL_ADDR_W-1:0] addr;
    input [`CPL_ADDR_W-1:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // ****************************************
  // State registers
  // ****************************************
  // Level, control and trap state
  reg [2:0]             priority_level_low_field_reg;
  reg [2:0]             priority_level_low_field_next;
  reg                   priority_level_high_bit_reg;
  reg                   priority_level_high_bit_next;
  reg                   nesting_disable_reg;
  reg                   nesting_disable_next;
  reg                   program_space_view_reg;
  reg                   program_space_view_next;
  reg [3:0]             trap_flags_reg;
  reg [3:0]             trap_flags_next;
  reg [`CPL_DATA_W-1:0] rdata_reg;
  reg [`CPL_DATA_W-1:0] rdata_next;

  // Decoded write strobes and trap requests
  wire wr_status;
  wire wr_control;
  wire wr_intctl1;
  wire [3:0] trap_hw_set;

  // Write decode
  assign wr_status  = reg_write_in & addr_hit(reg_addr_in, `CPL_ADDR_STATUS);
  assign wr_control = reg_write_in & addr_hit(reg_addr_in, `CPL_ADDR_CONTROL);
  assign wr_intctl1 = reg_write_in & addr_hit(reg_addr_in, `CPL_ADDR_INTCTL1);

  // Trap set requests in flag order 4..1
  assign trap_hw_set = {arith_error_trap_set_in, addr_error_trap_set_in,
                        stack_error_trap_set_in, osc_fail_trap_set_in};

  // ****************************************
  // Next state of the level bits
  // ****************************************

  // Core load beats any software write in the same cycle
  always @* begin
    priority_level_low_field_next = priority_level_low_field_reg;
    priority_level_high_bit_next  = priority_level_high_bit_reg;
    if (hw_level_load_in) begin
      priority_level_low_field_next = hw_level_in[2:0]; // RL7
      priority_level_high_bit_next  = hw_level_in[3];   // RL7
    end else begin
      // Low field locked while nesting is disabled
      if (wr_status && !nesting_disable_reg) begin // RL5
        priority_level_low_field_next =
          reg_wdata_in[`CPL_LVL_LO_MSB:`CPL_LVL_LO_LSB]; // RL1
      end
      // Software may clear the high bit, never set it
      if (wr_control && !reg_wdata_in[`CPL_LVL_HI_BIT]) begin
        priority_level_high_bit_next = 1'b0; // RL8
      end
    end
  end

  // ****************************************
  // Next state of control and trap bits
  // ****************************************

  // Hardware trap set wins over a software clear
  always @* begin
    nesting_disable_next    = nesting_disable_reg;
    program_space_view_next = program_space_view_reg;
    trap_flags_next         = trap_flags_reg;
    if (wr_intctl1) begin
      nesting_disable_next = reg_wdata_in[`CPL_NSTD_BIT]; // RL9
      trap_flags_next      = reg_wdata_in[`CPL_TRAP_MSB:`CPL_TRAP_LSB];
    end
    if (wr_control) begin
      program_space_view_next = reg_wdata_in[`CPL_PSV_BIT];
    end
    // A trap in the same cycle as a clear stays set
    trap_flags_next = trap_flags_next | trap_hw_set;
  end

  // ****************************************
  // Register images
  // ****************************************
  reg [`CPL_DATA_W-1:0] status_image;
  reg [`CPL_DATA_W-1:0] control_image;
  reg [`CPL_DATA_W-1:0] intctl1_image;

  // Unimplemented and foreign bits of each word read as zero
  always @* begin
    status_image  = `CPL_RDATA_ZERO;
    control_image = `CPL_RDATA_ZERO;
    intctl1_image = `CPL_RDATA_ZERO;
    status_image[`CPL_LVL_LO_MSB:`CPL_LVL_LO_LSB] = priority_level_low_field_reg; // RL6
    control_image[`CPL_LVL_HI_BIT]                = priority_level_high_bit_reg;  // RL3
    control_image[`CPL_PSV_BIT]                   = program_space_view_reg;
    intctl1_image[`CPL_NSTD_BIT]                  = nesting_disable_reg;          // RL9
    intctl1_image[`CPL_TRAP_MSB:`CPL_TRAP_LSB]    = trap_flags_reg;
  end

  // ****************************************
  // Read data path
  // ****************************************

  // Read answer, zero outside the read cycle
  always @* begin
    rdata_next = `CPL_RDATA_ZERO;
    if (reg_read_in) begin
      case (reg_addr_in)
        `CPL_ADDR_STATUS: begin
          rdata_next = status_image; // RL6
        end
        `CPL_ADDR_CONTROL: begin
          rdata_next = control_image;
        end
        `CPL_ADDR_INTCTL1: begin
          rdata_next = intctl1_image;
        end
        default: begin
          rdata_next = `CPL_RDATA_ZERO;
        end
      endcase
    end
  end

  // ****************************************
  // Register update
  // ****************************************

  // All level bits and nesting disable clear on reset
  always @(posedge clock_in or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      priority_level_low_field_reg <= `CPL_LVL_LO_RST; // RL10
      priority_level_high_bit_reg  <= 1'b0;            // RL10
      nesting_disable_reg          <= 1'b0;            // RL10
      program_space_view_reg       <= 1'b0;
      trap_flags_reg               <= `CPL_TRAP_RST;
      rdata_reg                    <= `CPL_RDATA_ZERO;
    end else begin
      priority_level_low_field_reg <= priority_level_low_field_next;
      priority_level_high_bit_reg  <= priority_level_high_bit_next;
      nesting_disable_reg          <= nesting_disable_next;
      program_space_view_reg       <= program_space_view_next;
      trap_flags_reg               <= trap_flags_next;
      rdata_reg                    <= rdata_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Effective level: field plus eight when high bit set
  assign cpu_priority_level_out =
    join_level(priority_level_high_bit_reg, priority_level_low_field_reg); // RL3 RL4

  // Field all ones or high bit set blocks every user source
  assign user_irq_blocked_out =
    (priority_level_low_field_reg == `CPL_LVL_LO_MAX) | priority_level_high_bit_reg; // RL2


  // Plain register copies towards the core
  assign nesting_disable_out    = nesting_disable_reg; // RL9
  assign program_space_view_out = program_space_view_reg;
  assign trap_flags_out         = trap_flags_reg;
  assign reg_rdata_out          = rdata_reg;

endmodule

`default_nettype wire

// *** design/cpl_rst_sync.v ***
// Reset release synchroniser for the priority level block
`timescale 1ns/1ps
`default_nettype none

module cpl_rst_sync (
  input  wire clock_in,
  input  wire rst_n_in,
  output wire rst_n_sync_out
);

  reg stage1_reg;
  reg stage2_reg;

  // Assert at once, release after two edges
  always @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= 1'b1;
      stage2_reg <= stage1_reg;
    end
  end

  assign rst_n_sync_out = stage2_reg;

endmodule

`default_nettype wire

// *** tb/cpl_core_model.sv ***
// Model of the core sequencer that loads levels and sets trap flags
`timescale 1ns/1ps
`default_nettype none
module cpl_core_model (
  input  wire logic       clock_in,
  input  wire logic       go_in,
  input  wire logic [3:0] lvl_in,
  input  wire logic [3:0] trap_in,
  output var  logic       load_out,
  output var  logic [3:0] lvl_out,
  output var  logic [3:0] trap_out
);
  // Level bus carries junk while no load is requested
  always @(posedge clock_in) begin
    load_out <= go_in;
    lvl_out  <= go_in ? lvl_in : ~lvl_in;
    trap_out <= trap_in;
  end
endmodule
`default_nettype wire

// *** tb/cpl_priority_level_monitor.sv ***
// Property checker for the priority level block
`timescale 1ns/1ps
`default_nettype none
module cpl_priority_level_monitor (
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic        hw_level_load_in,
  input wire logic [3:0]  hw_level_in,
  input wire logic [3:0]  cpu_priority_level_out,
  input wire logic        user_irq_blocked_out,
  input wire logic        nesting_disable_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  // Status write that the core does not override
  wire logic sw_st = reg_write_in && reg_addr_in == 4'h0 && !hw_level_load_in;
  hw_load_a:
    assert property (hw_level_load_in |=> cpu_priority_level_out == $past(hw_level_in))
    else $error("core level load lost");
  blocked_map_a:
    assert property (user_irq_blocked_out ==
      (&cpu_priority_level_out[2:0] || cpu_priority_level_out[3])) else $error("block wrong");
  nest_lock_a:
    assert property (sw_st && nesting_disable_out |=> $stable(cpu_priority_level_out[2:0]))
    else $error("locked field written");
  sw_low_a:
    assert property (sw_st && !nesting_disable_out |=>
      cpu_priority_level_out[2:0] == $past(reg_wdata_in[7:5])) else $error("field not written");
  hi_set_a:
    assert property (!hw_level_load_in && !cpu_priority_level_out[3] |=>
      !cpu_priority_level_out[3]) else $error("high bit set by software");
  rd_status_a:
    assert property (reg_read_in && reg_addr_in == 4'h0 |=> reg_rdata_out ==
      {8'h00, $past(cpu_priority_level_out[2:0]), 5'h00}) else $error("status read wrong");
  rd_ctrl_a:
    assert property (reg_read_in && reg_addr_in == 4'h1 |=> reg_rdata_out[15:3] ==
      {12'h000, $past(cpu_priority_level_out[3])}) else $error("control read wrong");
  nest_wr_a:
    assert property (reg_write_in && reg_addr_in == 4'h2 |=>
      nesting_disable_out == $past(reg_wdata_in[15])) else $error("nest bit not written");
endmodule
bind cpl_priority_level cpl_priority_level_monitor u_mon (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .hw_level_load_in(hw_level_load_in), .hw_level_in(hw_level_in),
  .cpu_priority_level_out(cpu_priority_level_out),
  .user_irq_blocked_out(user_irq_blocked_out), .nesting_disable_out(nesting_disable_out));
`default_nettype wire

// *** tb/cpl_priority_level_tb.sv ***
// Self-checking bench for the priority level block
`timescale 1ns/1ps
`default_nettype none
module cpl_priority_level_tb;
  logic        clock_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  lvl = 4'h0;
  logic [3:0]  trap = 4'h0;
  logic [3:0]  load_lvl, trap_set, level;
  logic        load, blocked, nest, program_space_view;
  logic [3:0]  traps;
  logic [15:0] rdata, v;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          cyc = 0;
  cpl_priority_level u_cpl_priority_level (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s), .reg_read_in(rd_s),
    .reg_rdata_out(rdata), .hw_level_load_in(load), .hw_level_in(load_lvl),
    .arith_error_trap_set_in(trap_set[3]), .addr_error_trap_set_in(trap_set[2]),
    .stack_error_trap_set_in(trap_set[1]), .osc_fail_trap_set_in(trap_set[0]),
    .cpu_priority_level_out(level), .user_irq_blocked_out(blocked),
    .nesting_disable_out(nest), .program_space_view_out(program_space_view), .trap_flags_out(traps));
  cpl_core_model u_cpl_core_model (.clock_in(clock_in), .go_in(go), .lvl_in(lvl),
    .trap_in(trap), .load_out(load), .lvl_out(load_lvl), .trap_out(trap_set));
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One register cycle: write when w, else read
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_in);
    addr  <= a;
    wdata <= d;
    wr_s  <= w;
    rd_s  <= !w;
    @(posedge clock_in);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    #1;
  endtask
  // Core request, taken two edges later
  task automatic core(input logic g, input logic [3:0] l, input logic [3:0] t);
    @(posedge clock_in);
    go   <= g;
    lvl  <= l;
    trap <= t;
    @(posedge clock_in);
    go   <= 1'b0;
    trap <= 4'h0;
    repeat (2) @(posedge clock_in);
    #1;
  endtask
  function automatic logic blk(input logic [3:0] l);
    return l[2:0] == 3'h7 || l[3];
  endfunction
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'h3962));
    repeat (5) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clock_in);
    #1;
    chk("level", 16'h0, {12'h0, level});
    chk("nest", 16'h0, {15'h0, nest});
    for (int i = 0; i < 20; i++) begin
      v = 16'($urandom);
      bus(1'b1, 4'h0, v);
      chk("level", {13'h0, v[7:5]}, {12'h0, level});
      bus(1'b0, 4'h0, 16'h0);
      chk("status", v & 16'h00e0, rdata);
    end
    bus(1'b1, 4'h1, 16'hffff);
    bus(1'b0, 4'h1, 16'h0);
    chk("control", 16'h0004, rdata);
    chk("psv", 16'h1, {15'h0, program_space_view});
    $display("software test done");
    for (int i = 0; i < 16; i++) begin
      core(1'b1, 4'(i), 4'h0);
      chk("level", 16'(i), {12'h0, level});
      chk("blocked", {15'h0, blk(4'(i))}, {15'h0, blocked});
    end
    bus(1'b0, 4'h1, 16'h0);
    chk("control", 16'h000c, rdata);
    bus(1'b1, 4'h1, 16'h0000);
    chk("level", 16'h7, {12'h0, level});
    chk("psv", 16'h0, {15'h0, program_space_view});
    $display("core test done");
    bus(1'b1, 4'h2, 16'h8000);
    chk("nest", 16'h1, {15'h0, nest});
    bus(1'b1, 4'h0, 16'h0020);
    chk("level", 16'h7, {12'h0, level});
    core(1'b0, 4'h0, 4'h8);
    bus(1'b0, 4'h2, 16'h0);
    chk("intctl", 16'h8010, rdata);
    chk("traps", 16'h8, {12'h0, traps});
    bus(1'b1, 4'h2, 16'h0000);
    chk("traps", 16'h0, {12'h0, traps});
    chk("nest", 16'h0, {15'h0, nest});
    bus(1'b1, 4'h0, 16'h0020);
    chk("level", 16'h1, {12'h0, level});
    // Trap set lands on the same edge as a software clear: set wins
    fork
      core(1'b0, 4'h0, 4'h1);
      begin
        @(posedge clock_in);
        bus(1'b1, 4'h2, 16'h0000);
      end
    join
    chk("traps", 16'h1, {12'h0, traps});
    bus(1'b0, 4'h2, 16'h0);
    chk("intctl", 16'h0002, rdata);
    bus(1'b0, 4'h5, 16'h0);
    chk("unmapped", 16'h0, rdata);
    $display("nesting test done");
    complete_run();
  end
endmodule
`default_nettype wire
